// ==== vr_bank_pkg.sv ====
// Constants, register map and state types of the regulator register bank
package vr_bank_pkg;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h11;
    localparam logic [7:0] ADDR_SNAPSHOT   = 8'h1c;
    localparam logic [7:0] ADDR_CUR_LIMIT  = 8'h21;
    localparam logic [7:0] ADDR_TEMP_LIMIT = 8'h22;
    localparam logic [7:0] ADDR_FAST_RATE  = 8'h24;
    localparam logic [7:0] ADDR_SLOW_RATE  = 8'h25;
    localparam logic [7:0] ADDR_BOOT_CODE  = 8'h26;
    localparam logic [7:0] ADDR_DIV_SELECT = 8'h2a;
    localparam logic [7:0] ADDR_OFF_EXIT   = 8'h2b;
    localparam logic [7:0] ADDR_ULP_EXIT   = 8'h2c;
    localparam logic [7:0] ADDR_EN_READY   = 8'h2d;
    localparam logic [7:0] ADDR_MAX_CODE   = 8'h30;
    localparam logic [7:0] ADDR_TARGET     = 8'h31;
    localparam logic [7:0] ADDR_PWR_STATE  = 8'h32;
    localparam logic [7:0] ADDR_MARGIN     = 8'h33;
    localparam logic [7:0] RST_ZERO        = 8'h00;
    localparam logic [7:0] RST_TEMP_LIMIT  = 8'h64;
    localparam logic [7:0] RST_FAST_RATE   = 8'h32;
    localparam logic [7:0] RST_DIV_SELECT  = 8'h02;
    localparam logic [7:0] RST_MAX_CODE    = 8'hb5;
    localparam logic [3:0] FIELD_BITS      = 4'h8;
    localparam logic [1:0] STRAP_SETTLE    = 2'h2;

    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_WDATA, PH_RDATA, PH_DONE} phase_t;

    typedef struct packed {
        logic [7:0] snapshot;
        logic [7:0] current_limit;
        logic [7:0] temperature_limit;
        logic [7:0] divider_select;
        logic [7:0] max_code;
        logic [7:0] target_code;
        logic [7:0] power_state;
        logic [7:0] margin;
    } bank_t;

    typedef struct packed {
        logic [1:0] clk_sync;
        logic [1:0] data_sync;
        logic [1:0] sel_sync;
        logic       clk_prev;
        logic [7:0] strap_s1;
        logic [7:0] strap_s2;
        phase_t     phase;
        logic [3:0] bit_cnt;
        logic       is_write;
        logic [7:0] addr;
        logic [7:0] shift;
        logic       data_out;
        logic       data_oe;
        bank_t      bank;
        logic [1:0] strap_wait;
        logic       strap_done;
        logic       boot_hold;
        logic       reject;
        logic       alert;
        logic [7:0] out_code;
    } state_t;
endpackage

// ==== vr_serial_vid_register_bank.sv ====
// Regulator register bank behind a sampled three-wire serial link
`timescale 1ns/1ns
// Function
// - Status two read copies into snapshot
// - Current limit strap captured once, read-only
// - Temperature limit resets 64h, drives alert
// - Fast ramp rate read-only, default 32h
// - Slow ramp rate reported, quarter by default
// - Hold boot code until voltage set
// - Selector divides fast rate, reset 02h
// - Off-state exit delay read-only
// - Ultra-low state exit delay read-only
// - Enable-to-ready delay read-only
// - Codes above maximum rejected, reset B5h
// - Target code writable, resets zero
// - Power state writable, resets zero
// - Signed margin offset added to target
// - Status two readable, read triggers snapshot
module vr_serial_vid_register_bank #(
    parameter logic [7:0] BOOT_CODE      = 8'h00,
    parameter logic [7:0] OFF_EXIT_US    = 8'h00,
    parameter logic [7:0] ULP_EXIT_US    = 8'h00,
    parameter logic [7:0] EN_READY_DELAY = 8'h00
) (
    input  wire logic       core_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       bus_clk_i,
    input  wire logic       bus_sel_i,
    input  wire logic       bus_data_i,
    output logic            bus_data_o,
    output logic            bus_data_oe_o,
    input  wire logic [7:0] current_limit_strap_pin_i,
    input  wire logic [7:0] status_two_i,
    input  wire logic [7:0] temperature_i,
    output logic            thermal_alert_output_o,
    output logic [7:0]      voltage_code_o,
    output logic [7:0]      ramp_rate_o,
    output logic [7:0]      power_state_o,
    output logic            voltage_code_reject_o
);
    import vr_bank_pkg::*;

    state_t st_reg;
    state_t st_next;
    logic   rise_c;
    logic   fall_c;
    logic   commit_c;
    logic   status_read_c;

    // A boot code above the reset limit could never be written back as a target
    if (BOOT_CODE > RST_MAX_CODE)
    begin : g_boot_code_check
        $error("boot code above reset maximum code");
    end

    function automatic logic [7:0] slow_rate(input logic [7:0] sel);
        logic [7:0] r;
        r = RST_FAST_RATE >> 2;
        case (sel)
            8'h01: r = RST_FAST_RATE >> 1;
            8'h03: r = RST_FAST_RATE >> 3;
            8'h04: r = RST_FAST_RATE >> 4;
            default: r = RST_FAST_RATE >> 2;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] read_value(input logic [7:0] a, input bank_t b, input logic [7:0] s2);
        logic [7:0] v;
        v = RST_ZERO;
        case (a)
            ADDR_STATUS_TWO: v = s2;
            ADDR_SNAPSHOT:   v = b.snapshot;
            ADDR_CUR_LIMIT:  v = b.current_limit;
            ADDR_TEMP_LIMIT: v = b.temperature_limit;
            ADDR_FAST_RATE:  v = RST_FAST_RATE;
            ADDR_SLOW_RATE:  v = slow_rate(b.divider_select);
            ADDR_BOOT_CODE:  v = BOOT_CODE;
            ADDR_DIV_SELECT: v = b.divider_select;
            ADDR_OFF_EXIT:   v = OFF_EXIT_US;
            ADDR_ULP_EXIT:   v = ULP_EXIT_US;
            ADDR_EN_READY:   v = EN_READY_DELAY;
            ADDR_MAX_CODE:   v = b.max_code;
            ADDR_TARGET:     v = b.target_code;
            ADDR_PWR_STATE:  v = b.power_state;
            ADDR_MARGIN:     v = b.margin;
            default:         v = RST_ZERO;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] margined(input logic [7:0] t, input logic [7:0] m);
        logic [9:0] sum;
        logic [7:0] r;
        sum = {2'b00, t} + {{2{m[7]}}, m};
        r = sum[7:0];
        if (sum[9])
        begin
            r = 8'h00;
        end
        else if (sum[8])
        begin
            r = 8'hff;
        end
        return r;
    endfunction

    always_comb
    begin
        logic [7:0] rv;
        rv = read_value(st_reg.addr, st_reg.bank, status_two_i);
        st_next = st_reg;
        rise_c = 1'b0;
        fall_c = 1'b0;
        commit_c = 1'b0;
        status_read_c = 1'b0;
        st_next.reject = 1'b0;
        // Only the second stage of each synchroniser feeds logic
        st_next.clk_sync = {st_reg.clk_sync[0], bus_clk_i};
        st_next.data_sync = {st_reg.data_sync[0], bus_data_i};
        st_next.sel_sync = {st_reg.sel_sync[0], bus_sel_i};
        st_next.strap_s1 = current_limit_strap_pin_i;
        st_next.strap_s2 = st_reg.strap_s1;
        st_next.clk_prev = st_reg.clk_sync[1];
        rise_c = st_reg.clk_sync[1] & ~st_reg.clk_prev;
        fall_c = ~st_reg.clk_sync[1] & st_reg.clk_prev;

        // Strap is read once the synchroniser holds pin values
        if (!st_reg.strap_done)
        begin
            if (st_reg.strap_wait == STRAP_SETTLE)
            begin
                st_next.bank.current_limit = st_reg.strap_s2;
                st_next.strap_done = 1'b1;
            end
            else
            begin
                st_next.strap_wait = st_reg.strap_wait + 2'h1;
            end
        end

        if (!st_reg.sel_sync[1])
        begin
            st_next.phase = PH_IDLE;
            st_next.data_oe = 1'b0;
            st_next.data_out = 1'b0;
        end
        else
        begin
            case (st_reg.phase)
                PH_IDLE:
                begin
                    if (rise_c)
                    begin
                        st_next.is_write = st_reg.data_sync[1];
                        st_next.bit_cnt = 4'h0;
                        st_next.phase = PH_ADDR;
                    end
                end
                PH_ADDR:
                begin
                    if (rise_c)
                    begin
                        st_next.addr = {st_reg.addr[6:0], st_reg.data_sync[1]};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                        if (st_reg.bit_cnt == FIELD_BITS - 4'h1)
                        begin
                            st_next.bit_cnt = 4'h0;
                            st_next.phase = st_reg.is_write ? PH_WDATA : PH_RDATA;
                        end
                    end
                end
                PH_WDATA:
                begin
                    if (rise_c)
                    begin
                        st_next.shift = {st_reg.shift[6:0], st_reg.data_sync[1]};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                        if (st_reg.bit_cnt == FIELD_BITS - 4'h1)
                        begin
                            commit_c = 1'b1;
                            st_next.phase = PH_DONE;
                        end
                    end
                end
                PH_RDATA:
                begin
                    // First cycle here loads the word; later falls shift it out
                    if (!st_reg.data_oe)
                    begin
                        st_next.shift = {rv[6:0], 1'b0};
                        st_next.data_out = rv[7];
                        st_next.data_oe = 1'b1;
                        if (st_reg.addr == ADDR_STATUS_TWO)
                        begin
                            status_read_c = 1'b1;
                            st_next.bank.snapshot = status_two_i;
                        end
                    end
                    else if (fall_c)
                    begin
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                        st_next.data_out = st_reg.shift[7];
                        st_next.shift = {st_reg.shift[6:0], 1'b0};
                        if (st_reg.bit_cnt == FIELD_BITS - 4'h1)
                        begin
                            st_next.data_oe = 1'b0;
                            st_next.data_out = 1'b0;
                            st_next.phase = PH_DONE;
                        end
                    end
                end
                PH_DONE:
                begin
                    st_next.data_oe = 1'b0;
                end
                default:
                begin
                    st_next.phase = PH_IDLE;
                end
            endcase
        end

        if (commit_c)
        begin
            // Read-only and unmapped addresses fall to the default
            case (st_reg.addr)
                ADDR_TEMP_LIMIT: st_next.bank.temperature_limit = st_next.shift;
                ADDR_DIV_SELECT: st_next.bank.divider_select = st_next.shift;
                ADDR_MAX_CODE:   st_next.bank.max_code = st_next.shift;
                ADDR_PWR_STATE:  st_next.bank.power_state = st_next.shift;
                ADDR_MARGIN:     st_next.bank.margin = st_next.shift;
                ADDR_TARGET:
                begin
                    if (st_next.shift > st_reg.bank.max_code)
                    begin
                        st_next.reject = 1'b1;
                    end
                    else
                    begin
                        st_next.bank.target_code = st_next.shift;
                        st_next.boot_hold = 1'b0;
                    end
                end
                default: st_next.bank = st_next.bank;
            endcase
        end

        st_next.alert = temperature_i >= st_reg.bank.temperature_limit;
        st_next.out_code = st_reg.boot_hold ? BOOT_CODE
                         : margined(st_reg.bank.target_code, st_reg.bank.margin);

        if (sys_rst_i)
        begin
            st_next = '0;
            st_next.phase = PH_IDLE;
            st_next.boot_hold = 1'b1;
            st_next.bank.temperature_limit = RST_TEMP_LIMIT;
            st_next.bank.divider_select = RST_DIV_SELECT;
            st_next.bank.max_code = RST_MAX_CODE;
            st_next.out_code = BOOT_CODE;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        st_reg <= st_next;
    end

    assign bus_data_o = st_reg.data_out;
    assign bus_data_oe_o = st_reg.data_oe;
    assign thermal_alert_output_o = st_reg.alert;
    assign voltage_code_o = st_reg.out_code;
    assign ramp_rate_o = slow_rate(st_reg.bank.divider_select);
    assign power_state_o = st_reg.bank.power_state;
    assign voltage_code_reject_o = st_reg.reject;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence seq_target_write;
        commit_c && st_reg.addr == ADDR_TARGET;
    endsequence

    sequence seq_over_limit;
        st_next.shift > st_reg.bank.max_code;
    endsequence

    sequence seq_read_start;
        st_reg.phase == PH_RDATA && !st_reg.data_oe && st_reg.sel_sync[1];
    endsequence

    sequence seq_state_write;
        commit_c && st_reg.addr == ADDR_PWR_STATE;
    endsequence

    a_snapshot_copy: assert property (status_read_c |=> st_reg.bank.snapshot == $past(status_two_i))
        else $error("snapshot not copied on status read");
    a_strap_held: assert property (st_reg.strap_done |=> $stable(st_reg.bank.current_limit))
        else $error("current limit changed after capture");
    a_thermal_alert: assert property (##1 thermal_alert_output_o
            == ($past(temperature_i) >= $past(st_reg.bank.temperature_limit)))
        else $error("thermal alert does not follow limit");
    a_reset_defaults: assert property ($past(sys_rst_i) |-> st_reg.bank.temperature_limit == 8'h64
            && st_reg.bank.divider_select == 8'h02 && st_reg.bank.max_code == 8'hb5
            && st_reg.bank.target_code == 8'h00 && st_reg.bank.power_state == 8'h00)
        else $error("register defaults wrong after reset");
    a_slow_default: assert property (st_reg.bank.divider_select == 8'h02 |-> ramp_rate_o == 8'h0c)
        else $error("slow rate not a quarter of fast rate");
    a_boot_hold: assert property (st_reg.boot_hold ##1 st_reg.boot_hold |-> voltage_code_o == BOOT_CODE)
        else $error("output left boot code early");
    a_reject_over: assert property (seq_target_write and seq_over_limit
            |=> voltage_code_reject_o && $stable(st_reg.bank.target_code))
        else $error("over-limit code not rejected");
    a_accept_under: assert property (seq_target_write and !(st_next.shift > st_reg.bank.max_code)
            |=> !voltage_code_reject_o && !st_reg.boot_hold)
        else $error("valid target code not accepted");
    a_margin_down: assert property (!st_reg.boot_hold && st_reg.bank.margin == 8'hff
            && st_reg.bank.target_code == 8'h40 ##1 $stable(st_reg.bank) |-> voltage_code_o == 8'h3f)
        else $error("negative margin not applied");
    a_ro_ignored: assert property (commit_c && st_reg.addr == ADDR_CUR_LIMIT && st_reg.strap_done
            |=> $stable(st_reg.bank.current_limit))
        else $error("read-only register was written");
    a_read_drive: assert property (seq_read_start ##1 st_reg.sel_sync[1] |-> bus_data_oe_o)
        else $error("read data not driven");
    a_limit_write: assert property (commit_c && st_reg.addr == ADDR_TEMP_LIMIT
            |=> st_reg.bank.temperature_limit == $past(st_next.shift))
        else $error("temperature limit write lost");
    a_divider_write: assert property (commit_c && st_reg.addr == ADDR_DIV_SELECT
            |=> st_reg.bank.divider_select == $past(st_next.shift))
        else $error("divider select write lost");
    a_state_write: assert property (seq_state_write |=> power_state_o == $past(st_next.shift))
        else $error("power state write lost");
    a_reject_pulse: assert property (voltage_code_reject_o |=> !voltage_code_reject_o)
        else $error("reject pulse longer than one cycle");
    a_snapshot_hold: assert property (!status_read_c |=> $stable(st_reg.bank.snapshot))
        else $error("snapshot changed without status read");
    a_frame_abort: assert property (!st_reg.sel_sync[1] |=> !bus_data_oe_o)
        else $error("data driven while frame deselected");
endmodule

// ==== host_link_model.sv ====
// Host side of the three-wire register link, driven from the core clock
`timescale 1ns/1ns
module host_link_model (
    input  wire logic core_clk_i,
    input  wire logic line_i,
    output logic      link_clk_o,
    output logic      sel_o,
    output logic      data_o,
    output logic      data_oe_o
);
    // Link clock stands low outside frames
    initial
    begin
        link_clk_o = 1'b0;
        sel_o      = 1'b0;
        data_o     = 1'b0;
        data_oe_o  = 1'b0;
    end

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask

    // Data set while clock low, held through the rising edge
    task automatic put_bit(input logic b, input int hi);
        link_clk_o <= 1'b0;
        data_oe_o  <= 1'b1;
        data_o     <= b;
        wait_cycles(4);
        link_clk_o <= 1'b1;
        wait_cycles(hi);
    endtask

    task automatic start(input logic wr, input logic [7:0] addr, input int last_hi);
        sel_o <= 1'b1;
        wait_cycles(4);
        put_bit(wr, 4);
        for (int i = 7; i >= 0; i--)
            put_bit(addr[i], (i == 0) ? last_hi : 4);
    endtask

    // Select stays low long enough for the device to see the gap
    task automatic stop();
        link_clk_o <= 1'b0;
        data_oe_o  <= 1'b0;
        wait_cycles(4);
        sel_o <= 1'b0;
        wait_cycles(8);
    endtask

    task automatic write_reg(input logic [7:0] addr, input logic [7:0] d);
        start(1'b1, addr, 4);
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], 4);
        stop();
    endtask

    // Released line reads as the pull-up; first bit needs a longer high phase
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] d);
        start(1'b0, addr, 1);
        data_oe_o <= 1'b0;
        wait_cycles(7);
        d[7] = line_i;
        for (int i = 6; i >= 0; i--)
        begin
            link_clk_o <= 1'b0;
            wait_cycles(4);
            link_clk_o <= 1'b1;
            wait_cycles(4);
            d[i] = line_i;
        end
        stop();
    endtask
endmodule

// ==== vr_serial_vid_register_bank_test.sv ====
// Self-checking bench for the regulator register bank
`timescale 1ns/1ns
module vr_serial_vid_register_bank_test;
    import vr_bank_pkg::*;
    logic       clk         = 1'b0;
    logic       rst         = 1'b1;
    logic [7:0] strap       = 8'h5a;
    logic [7:0] status_two  = 8'h00;
    logic [7:0] temperature = 8'h00;
    logic       link_clk;
    logic       sel;
    logic       host_data;
    logic       host_oe;
    logic       dev_data;
    logic       dev_oe;
    logic       alert;
    logic       reject;
    logic [7:0] vcode;
    logic [7:0] rate;
    logic [7:0] pstate;
    logic [7:0] rd;
    wire        line = dev_oe ? dev_data : (host_oe ? host_data : 1'b1);
    int         failures    = 0;
    int         comparisons = 0;
    int         rejects     = 0;
    logic [7:0] reg_addr [15] = '{8'h1c, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h2a, 8'h2b,
                                  8'h2c, 8'h2d, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34};
    logic [7:0] reg_dflt [15] = '{8'h00, 8'h5a, 8'h64, 8'h32, 8'h0c, 8'h2a, 8'h02, 8'h11,
                                  8'h22, 8'h33, 8'hb5, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [0:14] reg_ro     = 15'b110111011100000;

    always #10 clk = ~clk;

    always @(posedge clk)
        if (reject === 1'b1)
            rejects++;

    vr_serial_vid_register_bank #(
        .BOOT_CODE      (8'h2a),
        .OFF_EXIT_US    (8'h11),
        .ULP_EXIT_US    (8'h22),
        .EN_READY_DELAY (8'h33)
    ) vr_serial_vid_register_bank_i (
        .core_clk_i                (clk),
        .sys_rst_i                 (rst),
        .bus_clk_i                 (link_clk),
        .bus_sel_i                 (sel),
        .bus_data_i                (line),
        .bus_data_o                (dev_data),
        .bus_data_oe_o             (dev_oe),
        .current_limit_strap_pin_i (strap),
        .status_two_i              (status_two),
        .temperature_i             (temperature),
        .thermal_alert_output_o    (alert),
        .voltage_code_o            (vcode),
        .ramp_rate_o               (rate),
        .power_state_o             (pstate),
        .voltage_code_reject_o     (reject)
    );

    host_link_model host_link_model_i (
        .core_clk_i (clk),
        .line_i     (line),
        .link_clk_o (link_clk),
        .sel_o      (sel),
        .data_o     (host_data),
        .data_oe_o  (host_oe)
    );

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_link_model_i.read_reg(a, rd);
        chk(rd, exp);
    endtask

    task automatic test_defaults();
        chk(vcode, 8'h2a);
        chk(rate, 8'h0c);
        for (int i = 0; i < 15; i++)
            rd_chk(reg_addr[i], reg_dflt[i]);
        $display("test_defaults done");
    endtask

    // Strap moves after power-up; read-only values must not follow it
    task automatic test_read_only();
        @(posedge clk);
        strap <= 8'ha5;
        for (int i = 0; i < 15; i++)
            if (reg_ro[i])
                host_link_model_i.write_reg(reg_addr[i], 8'hff);
        for (int i = 0; i < 15; i++)
            rd_chk(reg_addr[i], reg_dflt[i]);
        $display("test_read_only done");
    endtask

    task automatic test_divider();
        for (int n = 1; n <= 4; n++)
        begin
            host_link_model_i.write_reg(ADDR_DIV_SELECT, 8'(n));
            chk(rate, RST_FAST_RATE >> n);
            rd_chk(ADDR_SLOW_RATE, RST_FAST_RATE >> n);
            rd_chk(ADDR_DIV_SELECT, 8'(n));
        end
        host_link_model_i.write_reg(ADDR_DIV_SELECT, 8'h07);
        chk(rate, RST_FAST_RATE >> 2);
        $display("test_divider done");
    endtask

    task automatic test_snapshot();
        @(posedge clk);
        status_two <= 8'ha5;
        rd_chk(ADDR_STATUS_TWO, 8'ha5);
        status_two <= 8'h3c;
        rd_chk(ADDR_SNAPSHOT, 8'ha5);
        $display("test_snapshot done");
    endtask

    task automatic test_thermal();
        host_link_model_i.write_reg(ADDR_TEMP_LIMIT, 8'h50);
        temperature <= 8'h4f;
        repeat (3) @(posedge clk);
        chk({7'h00, alert}, 8'h00);
        temperature <= 8'h50;
        repeat (3) @(posedge clk);
        chk({7'h00, alert}, 8'h01);
        rd_chk(ADDR_TEMP_LIMIT, 8'h50);
        $display("test_thermal done");
    endtask

    // Over-limit code is refused and the boot code stays on the output
    task automatic test_voltage();
        host_link_model_i.write_reg(ADDR_MAX_CODE, 8'h40);
        rejects = 0;
        host_link_model_i.write_reg(ADDR_TARGET, 8'h41);
        chk(8'(rejects), 8'h01);
        chk(vcode, 8'h2a);
        rd_chk(ADDR_TARGET, 8'h00);
        host_link_model_i.write_reg(ADDR_TARGET, 8'h40);
        chk(vcode, 8'h40);
        chk(8'(rejects), 8'h01);
        host_link_model_i.write_reg(ADDR_MARGIN, 8'hff);
        chk(vcode, 8'h3f);
        host_link_model_i.write_reg(ADDR_MARGIN, 8'h02);
        chk(vcode, 8'h42);
        host_link_model_i.write_reg(ADDR_PWR_STATE, 8'h03);
        chk(pstate, 8'h03);
        rd_chk(ADDR_MAX_CODE, 8'h40);
        $display("test_voltage done");
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        test_defaults();
        test_read_only();
        test_divider();
        test_snapshot();
        test_thermal();
        test_voltage();
        final_report();
    end

    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule
